// File: src/cmd_status_map.svh
// Offsets, field positions, reset values and fixed codes of the command/status word.
// Assumes inclusion by bare name from the package and from cmd_status_reg.
// Behaviour
// [RULE1] All-zero command isolates device except configuration
// [RULE2] Status bits clear on write one only
// [RULE3] Low half commands, high half reports status
// [RULE4] Any parity error sets bit 31
// [RULE5] Driving system error pin sets bit 30
// [RULE6] Own master abort sets received-master-abort flag
// [RULE7] Target abort of own master sets flag
// [RULE8] Device target abort sets bit 27
// [RULE9] Select speed field always reads 01
// [RULE10] Bit 24 needs pin, mastership, bit 6
// [RULE11] Back-to-back capable bit always reads one
// [RULE12] Reserved bits 22:21 read zero, ignore writes
// [RULE13] Hardware reset value is 02900000 hex
// [RULE14] Address parity system error needs bits 8,6
// [RULE15] Bit 6 clear: ignore parity errors, keep checking
// [RULE16] Bit 2 master, bit 1 memory, bit 0 io
// [RULE17] Event beats same-cycle clear of its flag
`ifndef CMD_STATUS_MAP_SVH
`define CMD_STATUS_MAP_SVH

// Configuration offset of the word (byte address, dword aligned)
`define CS_OFFSET 8'h04
// Hardware reset value of the whole word
`define CS_RESET 32'h0290_0000

// Command half: writable bits
`define CMD_IO_SPACE 0
`define CMD_MEM_SPACE 1
`define CMD_MASTER 2
`define CMD_PARITY_RESP 6
`define CMD_SYS_ERR 8
`define CMD_WMASK 16'h0147
`define CMD_RESET 16'h0000

// Status half: absolute bit positions in the word
`define ST_DETECTED_PARITY 31
`define ST_SIGNALED_SYS_ERR 30
`define ST_RCVD_MASTER_ABORT 29
`define ST_RCVD_TARGET_ABORT 28
`define ST_SIGNALED_TGT_ABORT 27
`define ST_SELECT_SPEED_HI 26
`define ST_SELECT_SPEED_LO 25
`define ST_MASTER_DATA_PARITY 24
`define ST_BACK_TO_BACK 23
`define ST_CAPABILITIES 20

// Fixed read values
`define SELECT_SPEED_MEDIUM 2'h1
`define BACK_TO_BACK_VALUE 1'h1
`define CAPABILITIES_VALUE 1'h1

// Index of each sticky flag inside the flag vector
`define FLAG_MASTER_DATA_PARITY 0
`define FLAG_SIGNALED_TGT_ABORT 1
`define FLAG_RCVD_TARGET_ABORT 2
`define FLAG_RCVD_MASTER_ABORT 3
`define FLAG_SIGNALED_SYS_ERR 4
`define FLAG_DETECTED_PARITY 5
`define FLAG_COUNT 6

`endif

// File: src/cmd_status_pkg.sv
// Types shared by the command/status register block.
// Assumes the map header is on the include path.
package cmd_status_pkg;
	`include "cmd_status_map.svh"

	// One configuration data word
	typedef logic [31:0] cfg_word_t;
	// Byte enables, active high, one per lane
	typedef logic [3:0] cfg_be_t;
	// Sticky status flags, indexed by the FLAG_ defines
	typedef logic [`FLAG_COUNT-1:0] flag_vec_t;

	// Expand byte enables into a bit mask; used for command writes and status clears
	function automatic cfg_word_t lane_mask(input cfg_be_t be);
		cfg_word_t m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction
endpackage

// File: src/sticky_flag.sv
// One sticky status flag: set by a hardware event, cleared by a write of one.
// Assumes event and clear are pulses on clk_sys.
`timescale 1ns/10ps
module sticky_flag (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic set_evt,
	input wire logic clr_req,
	output logic flag
);
	logic flag_reg; // Held flag
	logic flag_next; // Next flag value

	// Set wins over clear so an event in the clearing cycle survives
	always_comb begin
		flag_next = set_evt | (flag_reg & ~clr_req); // see [RULE17] see [RULE2]
	end

	// Register the flag; reset clears it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;
endmodule // sticky_flag

// File: src/sys_error_gen.sv
// Decides when the open-drain system error pin is pulled low.
// Assumes address parity errors arrive as one-cycle pulses from the bus core.
`timescale 1ns/10ps
module sys_error_gen (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic addr_parity_err,
	input wire logic system_error_enable,
	input wire logic parity_response_enable,
	output logic system_error_pin_out,
	output logic system_error_pin_oe
);
	logic oe_reg; // Pin driven low this cycle
	logic oe_next; // Next drive state

	// Both enables are needed; with parity response off the error is ignored
	always_comb begin
		oe_next = addr_parity_err & system_error_enable & parity_response_enable; // see [RULE14]
	end

	// One-cycle drive per detected address parity error
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= oe_next;
		end
	end

	assign system_error_pin_oe = oe_reg;
	// Open-drain: the driven level is always low
	assign system_error_pin_out = 1'b0;
endmodule // sys_error_gen

// File: src/cmd_status_reg.sv
// Configuration command/status word: command controls below, sticky status above.
// Assumes a configuration-cycle engine on clk_sys presents one-cycle read and
// write strobes, and that bus event pulses come from logic on the same clock.
`timescale 1ns/10ps
`include "cmd_status_map.svh"
module cmd_status_reg
	import cmd_status_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire cfg_be_t cfg_be,
	input wire cfg_word_t cfg_wdata,
	output cfg_word_t cfg_rdata,
	output logic cfg_rd_valid,
	input wire logic addr_parity_err,
	input wire logic data_parity_err,
	input wire logic parity_error_pin,
	input wire logic master_active,
	input wire logic master_abort_seen,
	input wire logic target_abort_seen,
	input wire logic target_abort_sent,
	output logic master_enable,
	output logic memory_space_enable,
	output logic io_space_enable,
	output logic parity_response_enable,
	output logic system_error_enable,
	output logic access_isolated,
	output logic system_error_pin_out,
	output logic system_error_pin_oe
);
	logic [15:0] cmd_reg; // Command half
	logic [15:0] cmd_next;
	logic isolated_reg; // All command bits zero
	logic isolated_next;
	cfg_word_t rdata_reg; // Read data holder
	cfg_word_t rdata_next;
	logic rd_valid_reg; // Read answer strobe
	logic rd_valid_next;
	flag_vec_t flag_set; // Hardware events per flag
	flag_vec_t flag_clr; // Write-one clears per flag
	flag_vec_t flags; // Current flag values
	cfg_word_t wmask; // Written lanes as bit mask
	cfg_word_t clr_bits; // Ones written to enabled lanes
	cfg_word_t word_view; // Word as software sees it
	logic hit; // Access targets this word
	logic serr_oe; // System error pin drive from the generator
	logic serr_out;

	// Address decode and lane masks
	always_comb begin
		hit = (cfg_addr == `CS_OFFSET);
		wmask = lane_mask(cfg_be);
		clr_bits = (cfg_wr && hit) ? (cfg_wdata & wmask) : 32'h0000_0000; // see [RULE2]
	end

	// Command half: only documented bits are writable, others stay zero
	always_comb begin
		cmd_next = cmd_reg;
		if (cfg_wr && hit) begin
			cmd_next = ((cfg_wdata[15:0] & wmask[15:0]) | (cmd_reg & ~wmask[15:0]))
				& `CMD_WMASK; // see [RULE3] see [RULE16]
		end
		// Zero command means no memory, io or master activity; config still answers
		isolated_next = (cmd_next == 16'h0000); // see [RULE1]
	end

	// Command half and isolation flag registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_reg <= `CMD_RESET; // see [RULE13]
			isolated_reg <= 1'b1;
		end else begin
			cmd_reg <= cmd_next;
			isolated_reg <= isolated_next;
		end
	end

	// Event sources for each sticky flag
	always_comb begin
		flag_set = '0;
		// Counted even with parity response off; checking never stops
		flag_set[`FLAG_DETECTED_PARITY] = addr_parity_err | data_parity_err; // see [RULE4] see [RULE15]
		// Taken from the pin drive itself so flag and pin agree
		flag_set[`FLAG_SIGNALED_SYS_ERR] = serr_oe; // see [RULE5]
		flag_set[`FLAG_RCVD_MASTER_ABORT] = master_abort_seen; // see [RULE6]
		flag_set[`FLAG_RCVD_TARGET_ABORT] = target_abort_seen; // see [RULE7]
		flag_set[`FLAG_SIGNALED_TGT_ABORT] = target_abort_sent; // see [RULE8]
		flag_set[`FLAG_MASTER_DATA_PARITY] = parity_error_pin & master_active
			& cmd_reg[`CMD_PARITY_RESP]; // see [RULE10]
	end

	// Map write-one bits onto flag indices
	always_comb begin
		flag_clr = '0;
		flag_clr[`FLAG_DETECTED_PARITY] = clr_bits[`ST_DETECTED_PARITY];
		flag_clr[`FLAG_SIGNALED_SYS_ERR] = clr_bits[`ST_SIGNALED_SYS_ERR];
		flag_clr[`FLAG_RCVD_MASTER_ABORT] = clr_bits[`ST_RCVD_MASTER_ABORT];
		flag_clr[`FLAG_RCVD_TARGET_ABORT] = clr_bits[`ST_RCVD_TARGET_ABORT];
		flag_clr[`FLAG_SIGNALED_TGT_ABORT] = clr_bits[`ST_SIGNALED_TGT_ABORT];
		flag_clr[`FLAG_MASTER_DATA_PARITY] = clr_bits[`ST_MASTER_DATA_PARITY];
	end

	// One sticky cell per status flag
	generate
		for (genvar g = 0; g < `FLAG_COUNT; g++) begin : g_flag
			sticky_flag u_flag (
				.clk_sys(clk_sys),
				.rstn(rstn),
				.set_evt(flag_set[g]),
				.clr_req(flag_clr[g]),
				.flag(flags[g])
			);
		end
	endgenerate

	// System error pin control
	sys_error_gen u_serr (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.addr_parity_err(addr_parity_err),
		.system_error_enable(cmd_reg[`CMD_SYS_ERR]),
		.parity_response_enable(cmd_reg[`CMD_PARITY_RESP]),
		.system_error_pin_out(serr_out),
		.system_error_pin_oe(serr_oe)
	);

	// Assemble the word; fixed fields are constants, reserved bits zero
	always_comb begin
		word_view = {16'h0000, cmd_reg};
		word_view[`ST_DETECTED_PARITY] = flags[`FLAG_DETECTED_PARITY];
		word_view[`ST_SIGNALED_SYS_ERR] = flags[`FLAG_SIGNALED_SYS_ERR];
		word_view[`ST_RCVD_MASTER_ABORT] = flags[`FLAG_RCVD_MASTER_ABORT];
		word_view[`ST_RCVD_TARGET_ABORT] = flags[`FLAG_RCVD_TARGET_ABORT];
		word_view[`ST_SIGNALED_TGT_ABORT] = flags[`FLAG_SIGNALED_TGT_ABORT];
		word_view[`ST_SELECT_SPEED_HI:`ST_SELECT_SPEED_LO] = `SELECT_SPEED_MEDIUM; // see [RULE9]
		word_view[`ST_MASTER_DATA_PARITY] = flags[`FLAG_MASTER_DATA_PARITY];
		word_view[`ST_BACK_TO_BACK] = `BACK_TO_BACK_VALUE; // see [RULE11]
		// Bits 22:21 and 19:16 keep the zeros of the first assignment
		word_view[`ST_CAPABILITIES] = `CAPABILITIES_VALUE; // see [RULE12]
	end

	// Read answer: one cycle after the strobe; other offsets read zero
	always_comb begin
		rd_valid_next = cfg_rd;
		rdata_next = rdata_reg;
		if (cfg_rd) begin
			rdata_next = hit ? word_view : 32'h0000_0000;
		end
	end

	// Read path registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 32'h0000_0000;
			rd_valid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign cfg_rd_valid = rd_valid_reg;
	assign master_enable = cmd_reg[`CMD_MASTER]; // see [RULE16]
	assign memory_space_enable = cmd_reg[`CMD_MEM_SPACE];
	assign io_space_enable = cmd_reg[`CMD_IO_SPACE];
	// Cleared bit tells the bus core to ignore parity errors
	assign parity_response_enable = cmd_reg[`CMD_PARITY_RESP]; // see [RULE15]
	assign system_error_enable = cmd_reg[`CMD_SYS_ERR];
	assign access_isolated = isolated_reg;
	assign system_error_pin_out = serr_out;
	assign system_error_pin_oe = serr_oe;
endmodule // cmd_status_reg

// File: tb/cfg_host.sv
// Host model issuing configuration reads and writes.
// Assumes the block's clk_sys; drives at the falling edge.
`timescale 1ns/10ps
module cfg_host (
	input wire logic clk_sys,
	input wire logic [31:0] rdata,
	input wire logic rd_valid,
	output logic wr,
	output logic rd,
	output logic [7:0] addr,
	output logic [3:0] be,
	output logic [31:0] wdata
);
	// Idle values at time zero
	initial begin
		wr = 0;
		rd = 0;
		addr = 8'hFB;
		be = 4'h0;
		wdata = 32'h0;
	end
	// One write strobe; idle bus then shows inverted address and data, not stale ones; byte enables keep their value
	task automatic put(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk_sys);
		wr = 1;
		addr = a;
		be = b;
		wdata = d;
		@(negedge clk_sys);
		wr = 0;
		addr = ~a;
		wdata = ~d;
	endtask
	// One read strobe; ok stays low if no answer within four cycles
	task automatic get(input logic [7:0] a, output logic [31:0] d, output logic ok);
		@(negedge clk_sys);
		rd = 1;
		addr = a;
		@(negedge clk_sys);
		rd = 0;
		addr = ~a;
		ok = 0;
		d = 32'h0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rd_valid === 1'b1) begin
				ok = 1;
				d = rdata;
			end else begin
				@(negedge clk_sys);
			end
		end
	endtask
endmodule // cfg_host

// File: tb/cmd_status_reg_chk.sv
// Port-level checks of the command/status block.
// Assumes binding into cmd_status_reg; one clock domain.
`timescale 1ns/10ps
module cmd_status_reg_chk
	import cmd_status_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire cfg_word_t cfg_rdata,
	input wire logic cfg_rd_valid,
	input wire logic addr_parity_err,
	input wire logic master_enable,
	input wire logic memory_space_enable,
	input wire logic io_space_enable,
	input wire logic parity_response_enable,
	input wire logic system_error_enable,
	input wire logic access_isolated,
	input wire logic system_error_pin_out,
	input wire logic system_error_pin_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_read_answer: assert property (cfg_rd |=> cfg_rd_valid)
		else $error("read not answered next cycle");
	a_valid_cause: assert property (cfg_rd_valid |-> $past(cfg_rd))
		else $error("read valid without strobe");
	a_fixed_fields: assert property (cfg_rd_valid && $past(cfg_addr) == 8'h04
		|-> (cfg_rdata[26:20] & 7'h6F) == 7'h29 && (cfg_rdata[15:0] & 16'hFEB8) == 16'h0)
		else $error("fixed or reserved bits wrong");
	a_isolation_level: assert property (access_isolated == !(master_enable ||
		memory_space_enable || io_space_enable || parity_response_enable || system_error_enable))
		else $error("isolation disagrees with command");
	a_serr_fires: assert property (addr_parity_err && system_error_enable
		&& parity_response_enable |=> system_error_pin_oe)
		else $error("system error not driven");
	a_serr_gated: assert property (system_error_pin_oe |->
		$past(addr_parity_err && system_error_enable && parity_response_enable))
		else $error("system error without cause");
	a_pin_low: assert property (!system_error_pin_out)
		else $error("pin driven high");
	a_reset_isolated: assert property ($rose(rstn) |-> access_isolated)
		else $error("not isolated after reset");
endmodule // cmd_status_reg_chk
bind cmd_status_reg cmd_status_reg_chk cmd_status_reg_chk_inst (.clk_sys, .rstn, .cfg_rd,
	.cfg_addr, .cfg_rdata, .cfg_rd_valid, .addr_parity_err, .master_enable, .memory_space_enable,
	.io_space_enable, .parity_response_enable, .system_error_enable, .access_isolated,
	.system_error_pin_out, .system_error_pin_oe);

// File: tb/tb.sv
// Self-checking bench for the command/status block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb;
	import cmd_status_pkg::*;
	logic clk_sys, rstn, cfg_wr, cfg_rd, cfg_rd_valid, iso, pin_out, pin_oe, ok;
	logic [7:0] cfg_addr;
	cfg_be_t cfg_be;
	cfg_word_t cfg_wdata, cfg_rdata, d;
	logic [6:0] ev, e;
	logic [4:0] en;
	logic [31:0] rnd;
	logic [15:0] cmd;
	int n_fail, n_tests;
	cmd_status_reg cmd_status_reg_inst (.clk_sys, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_rd_valid, .addr_parity_err(ev[0]), .data_parity_err(ev[1]),
		.parity_error_pin(ev[2]), .master_active(ev[3]), .master_abort_seen(ev[4]),
		.target_abort_seen(ev[5]), .target_abort_sent(ev[6]), .master_enable(en[2]),
		.memory_space_enable(en[1]), .io_space_enable(en[0]), .parity_response_enable(en[3]),
		.system_error_enable(en[4]), .access_isolated(iso), .system_error_pin_out(pin_out),
		.system_error_pin_oe(pin_oe));
	cfg_host cfg_host_inst (.clk_sys, .rdata(cfg_rdata), .rd_valid(cfg_rd_valid), .wr(cfg_wr),
		.rd(cfg_rd), .addr(cfg_addr), .be(cfg_be), .wdata(cfg_wdata));
	// Fixed-seed pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Flags an event pattern raises under a command
	function automatic logic [31:0] flags(input logic [6:0] x, input logic [15:0] c);
		return {x[0] | x[1], x[0] & c[8] & c[6], x[4], x[5], x[6], 2'b00, x[2] & x[3] & c[6], 24'h0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// A lost answer ends the run at once
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		cfg_host_inst.get(a, d, ok);
		if (!ok) begin
			n_fail++;
			results();
		end else begin
			chk("word", d, exp);
		end
	endtask
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		rstn = 0;
		ev = 7'h0;
		rnd = 32'hF57D196D;
		n_fail = 0;
		n_tests = 0;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1;
		rd_chk(8'h04, 32'h0290_0000);
		rd_chk(8'h08, 32'h0);
		// First seven passes are single events, the eighth drives events 0-3 together, then random mixes
		for (int k = 0; k < 40; k++) begin
			rnd = lfsr(rnd);
			cmd = rnd[15:0] & 16'h0147;
			e = (k < 7) ? 7'h1 << k : (k == 7) ? 7'h0F : rnd[22:16];
			cmd = (k < 7) ? 16'h0147 : (k == 7) ? 16'h0 : cmd;
			cfg_host_inst.put(8'h04, 4'h3, (k < 8) ? {16'h0, cmd} : rnd);
			chk("cmd", {iso, en}, {cmd == 16'h0, cmd[8], cmd[6], cmd[2:0]});
			@(negedge clk_sys);
			ev = e;
			@(negedge clk_sys);
			ev = 7'h0;
			repeat (2) @(negedge clk_sys);
			rd_chk(8'h04, 32'h0290_0000 | flags(e, cmd) | cmd);
			cfg_host_inst.put(8'h04, 4'hC, 32'h0);
			rd_chk(8'h04, 32'h0290_0000 | flags(e, cmd) | cmd);
			cfg_host_inst.put(8'h04, 4'hC, 32'hFFFF_FFFF);
			rd_chk(8'h04, 32'h0290_0000 | cmd);
		end
		cfg_host_inst.put(8'h14, 4'hF, 32'h0);
		rd_chk(8'h04, 32'h0290_0000 | cmd);
		fork
			cfg_host_inst.put(8'h04, 4'hC, 32'hFFFF_0000);
			begin
				@(negedge clk_sys);
				ev = 7'h10;
				@(negedge clk_sys);
				ev = 7'h0;
			end
		join
		rd_chk(8'h04, 32'h2290_0000 | cmd);
		// Ones on lane 2 meet only fixed bits; the flag in lane 3 must survive
		cfg_host_inst.put(8'h04, 4'h4, 32'hFFFF_FFFF);
		rd_chk(8'h04, 32'h2290_0000 | cmd);
		// Lane 0 alone clears the low enables; bit 8 in lane 1 stays
		cfg_host_inst.put(8'h04, 4'h1, 32'h0);
		rd_chk(8'h04, 32'h2290_0000 | (cmd & 16'h0100));
		// Mid-run reset drops the flag and brings back the reset word
		@(negedge clk_sys);
		rstn = 0;
		repeat (3) @(negedge clk_sys);
		rstn = 1;
		rd_chk(8'h04, 32'h0290_0000);
		cfg_host_inst.put(8'h04, 4'h3, 32'h0000_0147);
		chk("iso", iso, 32'h0);
		cfg_host_inst.put(8'h04, 4'hF, 32'h0);
		chk("iso", iso, 32'h1);
		results();
	end
endmodule // tb
